// [core/fswg_pkg.sv]
`default_nettype none
package fswg_pkg;
    // flash geometry, word addressed
    localparam int FSWG_ADDR_W = 16;
    localparam int FSWG_WORD_W = 16;
    localparam logic [FSWG_ADDR_W-1:0] FSWG_APP_LAST = 16'h77FF;
    localparam logic [FSWG_ADDR_W-1:0] FSWG_TBL_FIRST = 16'h7800;
    localparam logic [FSWG_ADDR_W-1:0] FSWG_TBL_LAST = 16'h7FFF;
    localparam logic [FSWG_ADDR_W-1:0] FSWG_BOOT_FIRST = 16'h8000;
    localparam logic [FSWG_ADDR_W-1:0] FSWG_BOOT_LAST = 16'h87FF;
    // lock level encodings, 2 bits per section
    localparam logic [1:0] FSWG_LOCK_NONE = 2'h3;
    localparam logic [1:0] FSWG_LOCK_NO_WRITE = 2'h2;
    localparam logic [1:0] FSWG_LOCK_NO_READ = 2'h1;
    localparam logic [1:0] FSWG_LOCK_ALL = 2'h0;
    localparam logic [5:0] FSWG_LOCK_RST = 6'h3F;

    typedef enum logic [2:0] {
        FSWG_SEC_APP = 3'h1,
        FSWG_SEC_TBL = 3'h2,
        FSWG_SEC_BOOT = 3'h4
    } fswg_sec_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [FSWG_ADDR_W-1:0] addr;
        logic [FSWG_WORD_W-1:0] wdata;
    } fswg_req_s;

    typedef struct packed {
        logic [1:0] boot;
        logic [1:0] tbl;
        logic [1:0] app;
    } fswg_lock_s;
endpackage
`default_nettype wire

// [core/fswg_guard.sv]
`default_nettype none
// Operation
// - flash holds 16-bit words; an instruction spans one or two words.
// - program stores start only when fetched from the boot section.
// - application and boot sections have independent lock bits.
// - application table has its own lock, separate from application.
// - map 0-77FF application, 7800-7FFF table, 8000-87FF boot.
// - table region is the same size as the boot section.
// - application protection comes from its own boot lock bits.
// - permitted stores may target any flash address, boot included.
// - boot protection comes from the boot loader lock bits.
// - external programmer and software both read and write flash.
// - fetch from the table region is allowed.
// - fetch from the boot section is allowed.
module fswg_guard
    import fswg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire fswg_lock_s lock_bits,
    input wire logic lock_load,
    input wire logic [FSWG_ADDR_W-1:0] fetch_pc,
    input wire logic fetch_valid,
    input wire fswg_req_s cpu_req,
    input wire fswg_req_s prog_req,
    output logic fetch_ok,
    output fswg_req_s flash_req,
    output logic cpu_refused,
    output logic prog_refused,
    output logic [1:0] cur_lock_app,
    output logic [1:0] cur_lock_tbl,
    output logic [1:0] cur_lock_boot
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_l_n;
    fswg_lock_s lock_q;
    fswg_req_s out_q;
    logic cpu_ref_q;
    logic prog_ref_q;

    function automatic fswg_sec_e sec_of(input logic [FSWG_ADDR_W-1:0] a);
        if (a <= FSWG_APP_LAST) begin
            sec_of = FSWG_SEC_APP;
        end else if (a <= FSWG_TBL_LAST) begin
            sec_of = FSWG_SEC_TBL;
        end else begin
            sec_of = FSWG_SEC_BOOT;
        end
    endfunction

    function automatic logic [1:0] lock_of(input fswg_sec_e s, input fswg_lock_s l);
        unique case (s)
            FSWG_SEC_APP: lock_of = l.app;
            FSWG_SEC_TBL: lock_of = l.tbl;
            FSWG_SEC_BOOT: lock_of = l.boot;
            default: lock_of = FSWG_LOCK_ALL;
        endcase
    endfunction

    function automatic logic in_flash(input logic [FSWG_ADDR_W-1:0] a);
        in_flash = a <= FSWG_BOOT_LAST;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_l_n = rst_s2_q;

    // lock bits only tighten once loaded; a loose value cannot reopen
    always_ff @(posedge clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            lock_q <= FSWG_LOCK_RST;
        end else if (lock_load) begin
            lock_q.app <= lock_q.app & lock_bits.app;
            lock_q.tbl <= lock_q.tbl & lock_bits.tbl;
            lock_q.boot <= lock_q.boot & lock_bits.boot;
        end
    end

    wire [1:0] cpu_lock = lock_of(sec_of(cpu_req.addr), lock_q);
    wire [1:0] prog_lock = lock_of(sec_of(prog_req.addr), lock_q);
    wire from_boot = fetch_valid && in_flash(fetch_pc) && sec_of(fetch_pc) == FSWG_SEC_BOOT;
    wire cpu_lock_ok = cpu_req.write ? cpu_lock[1] : cpu_lock[0];
    // programmer bypasses section locks except all-locked, flash range only
    wire prog_lock_ok = prog_lock != FSWG_LOCK_ALL;
    wire cpu_ok = cpu_req.valid && in_flash(cpu_req.addr) && cpu_lock_ok
        && (!cpu_req.write || from_boot);
    wire prog_ok = prog_req.valid && in_flash(prog_req.addr) && prog_lock_ok;
    // programmer wins when both request at once
    wire cpu_take = cpu_ok && !prog_req.valid;
    wire cpu_bad = cpu_req.valid && !cpu_take;
    wire prog_bad = prog_req.valid && !prog_ok;

    always_comb begin
        fetch_ok = fetch_valid && in_flash(fetch_pc);
    end

    always_ff @(posedge clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            out_q <= '0;
            cpu_ref_q <= 1'b0;
            prog_ref_q <= 1'b0;
        end else begin
            out_q <= prog_ok ? prog_req : (cpu_take ? cpu_req : '0);
            cpu_ref_q <= cpu_bad;
            prog_ref_q <= prog_bad;
        end
    end

    assign flash_req = out_q;
    assign cpu_refused = cpu_ref_q;
    assign prog_refused = prog_ref_q;
    assign cur_lock_app = lock_q.app;
    assign cur_lock_tbl = lock_q.tbl;
    assign cur_lock_boot = lock_q.boot;

    localparam logic [FSWG_ADDR_W-1:0] TBL_SIZE = FSWG_TBL_LAST - FSWG_TBL_FIRST;
    localparam logic [FSWG_ADDR_W-1:0] BOOT_SIZE = FSWG_BOOT_LAST - FSWG_BOOT_FIRST;

    // refusal pulse with nothing forwarded to the flash
    sequence s_cpu_refused_only;
        cpu_refused && !flash_req.valid;
    endsequence

    property p_store_needs_boot;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && cpu_req.write && !prog_req.valid && !from_boot) |=> !flash_req.valid && cpu_refused;
    endproperty
    a_store_needs_boot: assert property (p_store_needs_boot) else $error("store outside boot passed");

    property p_no_change;
        @(posedge clk) disable iff (!rst_l_n)
        (!prog_req.valid && cpu_req.write && !from_boot) |=> !(flash_req.valid && flash_req.write);
    endproperty
    a_no_change: assert property (p_no_change) else $error("flash write from non-boot store");

    property p_boot_store_anywhere;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && cpu_req.write && from_boot && !prog_req.valid && in_flash(cpu_req.addr)
            && lock_of(sec_of(cpu_req.addr), lock_q) == FSWG_LOCK_NONE)
        |=> flash_req.valid && flash_req.addr == $past(cpu_req.addr);
    endproperty
    a_boot_store_anywhere: assert property (p_boot_store_anywhere) else $error("permitted store dropped");

    property p_prog_access;
        @(posedge clk) disable iff (!rst_l_n)
        (prog_req.valid && in_flash(prog_req.addr) && lock_q == FSWG_LOCK_RST)
        |=> flash_req.valid && flash_req.wdata == $past(prog_req.wdata);
    endproperty
    a_prog_access: assert property (p_prog_access) else $error("programmer access lost");

    property p_tbl_own_lock;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && !cpu_req.write && !prog_req.valid && sec_of(cpu_req.addr) == FSWG_SEC_TBL
            && !lock_q.tbl[0]) |=> cpu_refused;
    endproperty
    a_tbl_own_lock: assert property (p_tbl_own_lock) else $error("table read lock ignored");

    property p_app_lock;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && cpu_req.write && from_boot && !prog_req.valid
            && sec_of(cpu_req.addr) == FSWG_SEC_APP && !lock_q.app[1]) |=> cpu_refused;
    endproperty
    a_app_lock: assert property (p_app_lock) else $error("application write lock ignored");

    property p_boot_lock;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && cpu_req.write && from_boot && !prog_req.valid
            && in_flash(cpu_req.addr) && sec_of(cpu_req.addr) == FSWG_SEC_BOOT && !lock_q.boot[1])
        |=> s_cpu_refused_only;
    endproperty
    a_boot_lock: assert property (p_boot_lock) else $error("boot write lock ignored");

    property p_lock_indep;
        @(posedge clk) disable iff (!rst_l_n)
        (lock_load && lock_bits.boot == FSWG_LOCK_NONE) |=> cur_lock_boot == $past(cur_lock_boot);
    endproperty
    a_lock_indep: assert property (p_lock_indep) else $error("boot lock disturbed");

    property p_fetch;
        @(posedge clk) disable iff (!rst_l_n)
        (fetch_valid && fetch_pc >= FSWG_TBL_FIRST && fetch_pc <= FSWG_BOOT_LAST) |-> fetch_ok;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch in table or boot refused");

    property p_same_size;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && sec_of(cpu_req.addr) == FSWG_SEC_TBL)
        |-> sec_of(cpu_req.addr - FSWG_TBL_FIRST + FSWG_BOOT_FIRST) == FSWG_SEC_BOOT
            && in_flash(cpu_req.addr - FSWG_TBL_FIRST + FSWG_BOOT_FIRST) && TBL_SIZE == BOOT_SIZE;
    endproperty
    a_same_size: assert property (p_same_size) else $error("table and boot sizes differ");

    property p_word;
        @(posedge clk) disable iff (!rst_l_n)
        (prog_req.valid && prog_ok) |=> $bits(flash_req.wdata) == FSWG_WORD_W && flash_req.valid;
    endproperty
    a_word: assert property (p_word) else $error("word transfer lost");

    property p_prog_wins;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && prog_req.valid) |=> cpu_refused;
    endproperty
    a_prog_wins: assert property (p_prog_wins) else $error("cpu access taken over programmer");

    property p_out_of_range;
        @(posedge clk) disable iff (!rst_l_n)
        (cpu_req.valid && !prog_req.valid && cpu_req.addr > FSWG_BOOT_LAST) |=> s_cpu_refused_only;
    endproperty
    a_out_of_range: assert property (p_out_of_range) else $error("access beyond flash forwarded");

    property p_prog_locked;
        @(posedge clk) disable iff (!rst_l_n)
        (prog_req.valid && lock_of(sec_of(prog_req.addr), lock_q) == FSWG_LOCK_ALL)
        |=> prog_refused && !flash_req.valid;
    endproperty
    a_prog_locked: assert property (p_prog_locked) else $error("fully locked section reached");

    // locks may only tighten until the next reset
    property p_lock_tighten;
        @(posedge clk) disable iff (!rst_l_n)
        1'b1 |=> (cur_lock_app & ~$past(cur_lock_app)) == 2'h0 && (cur_lock_tbl & ~$past(cur_lock_tbl)) == 2'h0
            && (cur_lock_boot & ~$past(cur_lock_boot)) == 2'h0;
    endproperty
    a_lock_tighten: assert property (p_lock_tighten) else $error("lock level loosened");

    property p_quiet;
        @(posedge clk) disable iff (!rst_l_n)
        (!cpu_req.valid && !prog_req.valid) |=> !flash_req.valid && !cpu_refused && !prog_refused;
    endproperty
    a_quiet: assert property (p_quiet) else $error("flash activity without request");
endmodule // fswg_guard
`default_nettype wire

// [verification/fswg_far_model.sv]
`default_nettype none
module fswg_far_model
    import fswg_pkg::*;
(
    input wire logic clk,
    input wire fswg_req_s cmd,
    output fswg_req_s prog_req
);
    timeunit 1ns;
    timeprecision 1ps;
    fswg_req_s last_q = '0;
    // idle bus shows the inverse of the last request, never a stale match
    assign prog_req = cmd.valid ? cmd : ~{1'b1, last_q[32:0]};
    always_ff @(posedge clk) begin
        if (cmd.valid) begin
            last_q <= cmd;
        end
    end
endmodule // fswg_far_model
`default_nettype wire

// [verification/fswg_guard_tb.sv]
`default_nettype none
module fswg_guard_tb
    import fswg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ld, fv, ok, cref, pref, e_cr, e_pr;
    logic [15:0] pc;
    logic [1:0] la, lt, lb;
    logic [31:0] seed = 32'h0000483B;
    int failures = 0, compares = 0;
    fswg_lock_s lk, ml;
    fswg_req_s cpu, cmd, prog, fl, e_fl;
    logic [15:0] bnd [8] = '{16'h0000, 16'h77FF, 16'h7800, 16'h7FFF, 16'h8000, 16'h87FF, 16'h8800, 16'hFFFF};
    fswg_guard i_fswg_guard (.clk(clk), .rst_n(rst_n), .lock_bits(lk), .lock_load(ld), .fetch_pc(pc),
        .fetch_valid(fv), .cpu_req(cpu), .prog_req(prog), .fetch_ok(ok), .flash_req(fl), .cpu_refused(cref),
        .prog_refused(pref), .cur_lock_app(la), .cur_lock_tbl(lt), .cur_lock_boot(lb));
    fswg_far_model i_fswg_far_model (.clk(clk), .cmd(cmd), .prog_req(prog));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // addresses cluster around section edges
    function automatic fswg_req_s mk(input logic [31:0] v);
        return '{v[0] & v[1], v[2], bnd[v[5:3]] ^ {12'h0, v[9:6]}, v[31:16]};
    endfunction
    function automatic logic [1:0] sec(input logic [15:0] a);
        return a > 16'h7FFF ? ml.boot : (a > 16'h77FF ? ml.tbl : ml.app);
    endfunction
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_flash(input fswg_req_s e, input fswg_req_s g);
        chk("flash_req", e, g);
    endtask
    task automatic chk_refused(input logic e_c, input logic e_p, input logic g_c, input logic g_p);
        chk("refused", {32'h0, e_c, e_p}, {32'h0, g_c, g_p});
    endtask
    task automatic chk_locks(input fswg_lock_s e, input logic [5:0] g);
        chk("locks", {28'h0, e}, {28'h0, g});
    endtask
    task automatic chk_fetch(input logic e, input logic g);
        chk("fetch_ok", {33'h0, e}, {33'h0, g});
    endtask
    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        logic [1:0] s;
        logic [31:0] v;
        for (int p = 0; p < 6; p++) begin
            rst_n = 1'b0;
            ld = 1'b0;
            fv = 1'b0;
            pc = '0;
            lk = '1;
            cpu = '0;
            cmd = '0;
            repeat (8) @(posedge clk);
            #1 rst_n = 1'b1;
            repeat (2) @(posedge clk);
            ml = '1;
            e_fl = '0;
            e_cr = 1'b0;
            e_pr = 1'b0;
            for (int i = 0; i < 200; i++) begin
                @(posedge clk);
                #1;
                chk_flash(e_fl, fl);
                chk_refused(e_cr, e_pr, cref, pref);
                chk_locks(ml, {lb, lt, la});
                v = rnd();
                // phase 0 keeps everything open; later phases tighten once
                ld = (i == 5 && p > 0);
                lk = v[5:0];
                fv = v[6];
                pc = bnd[v[9:7]] ^ {12'h0, v[13:10]};
                cpu = ld ? '0 : mk(rnd());
                cmd = ld ? '0 : mk(rnd());
                #1;
                e_fl = '0;
                e_pr = prog.valid && (prog.addr > 16'h87FF || sec(prog.addr) == 2'h0);
                if (prog.valid && !e_pr) e_fl = prog;
                s = sec(cpu.addr);
                e_cr = cpu.valid && (prog.valid || cpu.addr > 16'h87FF || !s[cpu.write]
                    || (cpu.write && !(fv && pc[15:11] == 5'h10)));
                if (cpu.valid && !e_cr) e_fl = cpu;
                if (ld) ml = ml & lk;
                chk_fetch(fv && pc <= 16'h87FF, ok);
            end
            // answer to the last request of the phase, before reset hits again
            @(posedge clk);
            #1;
            chk_flash(e_fl, fl);
            chk_refused(e_cr, e_pr, cref, pref);
            $display("phase %0d done", p);
        end
        give_verdict();
    end
endmodule // fswg_guard_tb
`default_nettype wire
